// *** logic/acsp_pkg.sv ***
`default_nettype none
package acsp_pkg;

  // ****************************************
  // Serial word layout
  // ****************************************
  localparam int         WORD_BITS      = 16;
  localparam int         ADDR_BITS      = 5;
  localparam int         DATA_BITS      = 11;
  localparam logic [3:0] LAST_BIT_INDEX = 4'hf;

  // ****************************************
  // Device registers and fields
  // ****************************************
  localparam logic [4:0]  ADDR_MAIN      = 5'h00;
  localparam logic [4:0]  ADDR_FORMAT    = 5'h0a;
  localparam logic [10:0] REG_DEFAULT    = 11'h000;
  localparam int          BIT_STANDBY    = 0;
  localparam int          BIT_CLKOUT_OFF = 2;
  localparam int          BIT_SOFT_RESET = 4;
  localparam int          BIT_REF_EXT    = 5;
  localparam int          BIT_CMOS       = 8;
  localparam int          BIT_COARSE     = 9;
  localparam int          BIT_OBUF_OFF   = 10;
  localparam int          BIT_STRAIGHT   = 10;

  // Quantised level of an analog control pin
  typedef enum logic [1:0] {
    LEVEL_ZERO = 2'h0,
    LEVEL_3_8  = 2'h1,
    LEVEL_5_8  = 2'h2,
    LEVEL_FULL = 2'h3
  } acsp_level_type;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_PERIOD_NS         = 10;
  localparam int POWER_ON_MS             = 5;
  localparam int POWER_ON_CYCLES_DEFAULT = POWER_ON_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int RESET_PULSE_NS          = 10;
  // Pulse must be strictly longer than the figure
  localparam int RESET_PULSE_CYCLES      = RESET_PULSE_NS / CLOCK_PERIOD_NS + 1;
  localparam int WRITE_DELAY_NS          = 25;
  localparam int WRITE_DELAY_CYCLES      = (WRITE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SERIAL_SETUP_NS         = 25;
  localparam int SCLK_MAX_MHZ            = 20;
  localparam int SCLK_MIN_HALF_NS        = 1000 / (2 * SCLK_MAX_MHZ);
  localparam int SCLK_HALF_NS            = (SERIAL_SETUP_NS > SCLK_MIN_HALF_NS) ? SERIAL_SETUP_NS
                                                                                : SCLK_MIN_HALF_NS;
  localparam int SCLK_HALF_CYCLES        = (SCLK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ****************************************
  // Host controller registers
  // ****************************************
  localparam logic [3:0] HOST_REG_COMMAND = 4'h0;
  localparam logic [3:0] HOST_REG_CONTROL = 4'h4;
  localparam logic [3:0] HOST_REG_STATUS  = 4'h8;
  localparam int         CTRL_PIN_MODE    = 0;
  localparam int         CTRL_SCLK_LEVEL  = 1;
  localparam int         CTRL_SEL_LEVEL   = 3;
  localparam int         CTRL_STATIC_DATA = 5;
  localparam int         CTRL_PDN         = 6;
  localparam int         CTRL_HW_RESET    = 7;
  localparam logic [7:0] CTRL_DEFAULT     = 8'h00;
  localparam int         STAT_BUSY        = 0;
  localparam int         STAT_READY       = 1;
  localparam int         STAT_PIN_MODE    = 2;
  localparam int         STAT_REFUSED     = 3;

endpackage
`default_nettype wire

// *** logic/acsp_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface acsp_link_if;
  logic       reset_pin;
  logic       port_select_n;
  logic       shift_clock;
  logic       shift_data_pin;
  logic       power_down_pin;
  // Quantised analog levels of the select and shift clock pins
  logic [1:0] shift_clock_level;
  logic [1:0] port_select_level;

  modport host (
    output reset_pin,
    output port_select_n,
    output shift_clock,
    output shift_data_pin,
    output power_down_pin,
    output shift_clock_level,
    output port_select_level
  );

  modport device (
    input reset_pin,
    input port_select_n,
    input shift_clock,
    input shift_data_pin,
    input power_down_pin,
    input shift_clock_level,
    input port_select_level
  );
endinterface
`default_nettype wire

// *** logic/acsp_device.sv ***
// Summary of operation
// - Reset pin low enables serial register port
// - Reset pulse or soft reset restores defaults
// - Reset pin high makes pins static selects
// - Shift clock level picks reference and gain
// - Select level picks format and interface
// - Data and power-down pins pick power state
// - Host initialises registers after power-up
// - Shift data sampled on falling edges, select low
// - Every 16th falling edge commits a word
// - Trailing partial word bits are discarded
// - Word is 5 address then 11 data bits
// - Works from few hertz up to 20 MHz
// - Soft reset bit clears itself after reset
// - Host waits 5 ms before reset pulse
// - Host waits 25 ns before select low
// - Host writes zero into unused bits; acsp_host shifts wdata[15:0] out unmasked
`timescale 1ns/1ps
`default_nettype none
module acsp_device (
  // Link to host
  acsp_link_if.device link,
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Effective configuration
  output logic             serial_mode,
  output logic             ref_external,
  output logic             coarse_gain_on,
  output logic             cmos_interface,
  output logic             straight_binary,
  output logic             adc_standby,
  output logic             output_buffers_off,
  output logic             clkout_buffer_off,
  output logic             global_power_down,
  // Register write report
  output logic             reg_write_pulse,
  output logic [4:0]       reg_write_addr,
  output logic [10:0]      reg_write_data
);

  // ****************************************
  // Link domain: shifter
  // ****************************************
  logic [3:0]  bit_count;
  logic [14:0] shift_hold;
  logic [10:0] reg_main;
  logic [10:0] reg_format;
  logic [4:0]  event_addr;
  logic [10:0] event_data;
  logic        event_toggle;

  // Select high or reset high keeps the shifter idle
  wire         link_clear = link.port_select_n | link.reset_pin;
  wire  [15:0] full_word  = {shift_hold, link.shift_data_pin};
  wire  [4:0]  word_addr  = full_word[15:11];
  wire  [10:0] word_data  = full_word[10:0];
  wire         word_done  = bit_count == acsp_pkg::LAST_BIT_INDEX;
  wire         soft_reset = (word_addr == acsp_pkg::ADDR_MAIN) && word_data[acsp_pkg::BIT_SOFT_RESET];

  // Runs on the shift clock itself, so any rate up to the limit works
  always_ff @(negedge link.shift_clock or posedge link_clear)
  begin
    if (link_clear)
    begin
      bit_count  <= 4'h0;
      shift_hold <= 15'h0000;
    end
    else
    begin
      bit_count  <= bit_count + 4'h1;
      shift_hold <= {shift_hold[13:0], link.shift_data_pin};
    end
  end

  // ****************************************
  // Link domain: registers
  // ****************************************
  always_ff @(negedge link.shift_clock or posedge link.reset_pin)
  begin
    if (link.reset_pin)
    begin
      reg_main     <= acsp_pkg::REG_DEFAULT;
      reg_format   <= acsp_pkg::REG_DEFAULT;
      event_addr   <= 5'h00;
      event_data   <= 11'h000;
      event_toggle <= 1'b0;
    end
    else if (word_done && !link.port_select_n)
    begin
      event_addr   <= word_addr;
      event_data   <= word_data;
      event_toggle <= ~event_toggle;
      if (soft_reset)
      begin
        // Soft reset bit is never stored, so it reads back as zero
        reg_main   <= acsp_pkg::REG_DEFAULT;
        reg_format <= acsp_pkg::REG_DEFAULT;
      end
      else if (word_addr == acsp_pkg::ADDR_MAIN)
      begin
        reg_main   <= word_data;
      end
      else if (word_addr == acsp_pkg::ADDR_FORMAT)
      begin
        reg_format <= word_data;
      end
    end
  end

  // ****************************************
  // System domain: synchronisers
  // ****************************************
  logic [7:0] sync_meta;
  logic [7:0] sync_level;
  logic       reset_catch;
  logic       catch_meta;
  logic       catch_sync;
  logic       toggle_seen;

  wire  [7:0] sync_in = {link.reset_pin, link.shift_data_pin, link.power_down_pin,
                         link.shift_clock_level, link.port_select_level, event_toggle};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync_meta  <= 8'h00;
      sync_level <= 8'h00;
    end
    else
    begin
      sync_meta  <= sync_in;
      sync_level <= sync_meta;
    end
  end

  // A short reset pulse may fall between clock edges, so it is caught first
  always_ff @(posedge clock or posedge rst or posedge link.reset_pin)
  begin
    if (rst)
    begin
      reset_catch <= 1'b0;
    end
    else if (link.reset_pin)
    begin
      reset_catch <= 1'b1;
    end
    else if (catch_sync)
    begin
      reset_catch <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      catch_meta <= 1'b0;
      catch_sync <= 1'b0;
    end
    else
    begin
      catch_meta <= reset_catch;
      catch_sync <= catch_meta;
    end
  end

  wire       pin_mode     = sync_level[7];
  wire       data_level   = sync_level[6];
  wire       pdn_level    = sync_level[5];
  wire [1:0] sclk_level   = sync_level[4:3];
  wire [1:0] sel_level    = sync_level[2:1];
  wire       toggle_sync  = sync_level[0];
  wire       write_event  = (toggle_sync != toggle_seen) && !catch_sync;

  // ****************************************
  // System domain: register shadows
  // ****************************************
  logic [10:0] shadow_main;
  logic [10:0] shadow_format;

  // Link registers are still while the toggle crosses: next word is 16 shift clocks away
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      shadow_main     <= acsp_pkg::REG_DEFAULT;
      shadow_format   <= acsp_pkg::REG_DEFAULT;
      toggle_seen     <= 1'b0;
      reg_write_pulse <= 1'b0;
      reg_write_addr  <= 5'h00;
      reg_write_data  <= 11'h000;
    end
    else
    begin
      toggle_seen     <= toggle_sync;
      reg_write_pulse <= write_event;
      if (catch_sync)
      begin
        shadow_main   <= acsp_pkg::REG_DEFAULT;
        shadow_format <= acsp_pkg::REG_DEFAULT;
      end
      else if (write_event)
      begin
        shadow_main    <= reg_main;
        shadow_format  <= reg_format;
        reg_write_addr <= event_addr;
        reg_write_data <= event_data;
      end
    end
  end

  // ****************************************
  // Pin-control decode
  // ****************************************
  wire pin_ref_ext  = (sclk_level == acsp_pkg::LEVEL_3_8) || (sclk_level == acsp_pkg::LEVEL_5_8);
  wire pin_coarse   = (sclk_level == acsp_pkg::LEVEL_5_8) || (sclk_level == acsp_pkg::LEVEL_FULL);
  wire pin_straight = (sel_level == acsp_pkg::LEVEL_3_8) || (sel_level == acsp_pkg::LEVEL_5_8);
  wire pin_cmos     = (sel_level == acsp_pkg::LEVEL_5_8) || (sel_level == acsp_pkg::LEVEL_FULL);
  wire pin_standby  = !data_level && pdn_level;
  wire pin_obuf_off = data_level && !pdn_level;
  wire pin_global   = data_level && pdn_level;

  // ****************************************
  // Output selection
  // ****************************************
  wire next_ref_external       = pin_mode ? pin_ref_ext  : shadow_main[acsp_pkg::BIT_REF_EXT];
  wire next_coarse_gain_on     = pin_mode ? pin_coarse   : shadow_main[acsp_pkg::BIT_COARSE];
  wire next_cmos_interface     = pin_mode ? pin_cmos     : shadow_main[acsp_pkg::BIT_CMOS];
  wire next_straight_binary    = pin_mode ? pin_straight : shadow_format[acsp_pkg::BIT_STRAIGHT];
  wire next_adc_standby        = pin_mode ? pin_standby  : shadow_main[acsp_pkg::BIT_STANDBY];
  wire next_output_buffers_off = pin_mode ? pin_obuf_off : shadow_main[acsp_pkg::BIT_OBUF_OFF];
  wire next_clkout_buffer_off  = pin_mode ? 1'b0         : shadow_main[acsp_pkg::BIT_CLKOUT_OFF];
  wire next_global_power_down  = pin_mode && pin_global;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      serial_mode        <= 1'b0;
      ref_external       <= 1'b0;
      coarse_gain_on     <= 1'b0;
      cmos_interface     <= 1'b0;
      straight_binary    <= 1'b0;
      adc_standby        <= 1'b0;
      output_buffers_off <= 1'b0;
      clkout_buffer_off  <= 1'b0;
      global_power_down  <= 1'b0;
    end
    else
    begin
      serial_mode        <= !pin_mode;
      ref_external       <= next_ref_external;
      coarse_gain_on     <= next_coarse_gain_on;
      cmos_interface     <= next_cmos_interface;
      straight_binary    <= next_straight_binary;
      adc_standby        <= next_adc_standby;
      output_buffers_off <= next_output_buffers_off;
      clkout_buffer_off  <= next_clkout_buffer_off;
      global_power_down  <= next_global_power_down;
    end
  end

endmodule
`default_nettype wire

// *** logic/acsp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module acsp_host #(
  parameter int POWER_ON_CYCLES = acsp_pkg::POWER_ON_CYCLES_DEFAULT
) (
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Software port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        write,
  input  wire logic        read,
  output logic      [31:0] rdata,
  // Link to device
  acsp_link_if.host        link
);

  typedef enum logic [7:0] {
    S_POWER_WAIT = 8'b0000_0001,
    S_RESET      = 8'b0000_0010,
    S_RECOVER    = 8'b0000_0100,
    S_IDLE       = 8'b0000_1000,
    S_PIN        = 8'b0001_0000,
    S_SETUP      = 8'b0010_0000,
    S_SHIFT      = 8'b0100_0000,
    S_HOLD       = 8'b1000_0000
  } acsp_host_state_type;

  acsp_host_state_type state;
  logic [18:0] wait_count;
  logic [3:0]  bit_count;
  logic [15:0] shift_word;
  logic [7:0]  control;
  logic        reset_request;
  logic        refused;
  logic        init_done;

  // ****************************************
  // Decode
  // ****************************************
  wire cmd_write    = write && (addr == acsp_pkg::HOST_REG_COMMAND);
  wire ctrl_write   = write && (addr == acsp_pkg::HOST_REG_CONTROL);
  wire status_read  = read && (addr == acsp_pkg::HOST_REG_STATUS);
  wire pin_mode     = control[acsp_pkg::CTRL_PIN_MODE];
  wire cmd_take     = cmd_write && (state == S_IDLE) && !pin_mode;
  wire power_done   = wait_count == 19'(POWER_ON_CYCLES - 1);
  wire pulse_done   = wait_count == 19'(acsp_pkg::RESET_PULSE_CYCLES - 1);
  wire recover_done = wait_count == 19'(acsp_pkg::WRITE_DELAY_CYCLES - 1);
  wire half_done    = wait_count == 19'(acsp_pkg::SCLK_HALF_CYCLES - 1);
  wire busy         = (state != S_IDLE) && (state != S_PIN);
  wire [31:0] status_word = {28'h0000000, refused, pin_mode, init_done, busy};
  wire [31:0] next_rdata  = (addr == acsp_pkg::HOST_REG_CONTROL) ? {24'h000000, control}
                          : (addr == acsp_pkg::HOST_REG_STATUS)  ? status_word
                          : 32'h00000000;

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      control       <= acsp_pkg::CTRL_DEFAULT;
      reset_request <= 1'b0;
      refused       <= 1'b0;
      rdata         <= 32'h00000000;
    end
    else
    begin
      rdata <= read ? next_rdata : 32'h00000000;
      if (ctrl_write)
      begin
        control <= wdata[7:0];
      end
      // Setting wins over the clear in the same cycle
      if (ctrl_write && wdata[acsp_pkg::CTRL_HW_RESET])
      begin
        reset_request <= 1'b1;
      end
      // Cleared once the pulse starts, so a command taken in idle cannot swallow it
      else if (state == S_RESET)
      begin
        reset_request <= 1'b0;
      end
      if (cmd_write && !cmd_take)
      begin
        refused <= 1'b1;
      end
      else if (status_read)
      begin
        refused <= 1'b0;
      end
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state               <= S_POWER_WAIT;
      wait_count          <= 19'h00000;
      bit_count           <= 4'h0;
      shift_word          <= 16'h0000;
      init_done           <= 1'b0;
      link.reset_pin      <= 1'b0;
      link.port_select_n  <= 1'b1;
      link.shift_clock    <= 1'b0;
      link.shift_data_pin <= 1'b0;
    end
    else
    begin
      wait_count <= wait_count + 19'h00001;
      case (state)
        S_POWER_WAIT:
        begin
          if (power_done)
          begin
            link.reset_pin <= 1'b1;
            wait_count     <= 19'h00000;
            state          <= S_RESET;
          end
        end
        S_RESET:
        begin
          if (pin_mode)
          begin
            state <= S_PIN;
          end
          else if (pulse_done)
          begin
            link.reset_pin <= 1'b0;
            wait_count     <= 19'h00000;
            state          <= S_RECOVER;
          end
        end
        S_RECOVER:
        begin
          if (recover_done)
          begin
            init_done <= 1'b1;
            state     <= S_IDLE;
          end
        end
        S_IDLE:
        begin
          if (pin_mode)
          begin
            link.reset_pin <= 1'b1;
            init_done      <= 1'b0;
            state          <= S_PIN;
          end
          else if (cmd_take)
          begin
            // Bits above the word are dropped; software keeps unused fields zero
            shift_word          <= wdata[15:0];
            link.shift_data_pin <= wdata[15];
            link.port_select_n  <= 1'b0;
            bit_count           <= 4'h0;
            wait_count          <= 19'h00000;
            state               <= S_SETUP;
          end
          else if (reset_request)
          begin
            link.reset_pin <= 1'b1;
            init_done      <= 1'b0;
            wait_count     <= 19'h00000;
            state          <= S_RESET;
          end
        end
        S_PIN:
        begin
          // Static levels come straight from the control register
          link.shift_data_pin <= control[acsp_pkg::CTRL_STATIC_DATA];
          if (!pin_mode)
          begin
            link.reset_pin      <= 1'b0;
            link.shift_data_pin <= 1'b0;
            wait_count          <= 19'h00000;
            state               <= S_RECOVER;
          end
        end
        S_SETUP:
        begin
          if (half_done)
          begin
            link.shift_clock <= 1'b1;
            wait_count       <= 19'h00000;
            state            <= S_SHIFT;
          end
        end
        S_SHIFT:
        begin
          if (half_done)
          begin
            wait_count       <= 19'h00000;
            link.shift_clock <= ~link.shift_clock;
            if (link.shift_clock)
            begin
              bit_count <= bit_count + 4'h1;
              if (bit_count == acsp_pkg::LAST_BIT_INDEX)
              begin
                state <= S_HOLD;
              end
            end
            else
            begin
              // Data moves on the rising edge, half a period from either falling edge
              link.shift_data_pin <= shift_word[14];
              shift_word          <= {shift_word[14:0], 1'b0};
            end
          end
        end
        S_HOLD:
        begin
          if (half_done)
          begin
            link.port_select_n  <= 1'b1;
            link.shift_data_pin <= 1'b0;
            bit_count           <= 4'h0;
            state               <= S_IDLE;
          end
        end
        default:
        begin
          state <= S_POWER_WAIT;
        end
      endcase
    end
  end

  // ****************************************
  // Static pins
  // ****************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      link.power_down_pin    <= 1'b0;
      link.shift_clock_level <= 2'h0;
      link.port_select_level <= 2'h0;
    end
    else
    begin
      link.power_down_pin    <= control[acsp_pkg::CTRL_PDN];
      link.shift_clock_level <= control[acsp_pkg::CTRL_SCLK_LEVEL +: 2];
      link.port_select_level <= control[acsp_pkg::CTRL_SEL_LEVEL +: 2];
    end
  end

endmodule
`default_nettype wire

// *** sim/acsp_link_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Link checks
// ****
module acsp_link_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link and device
  input wire logic reset_pin,
  input wire logic port_select_n,
  input wire logic shift_clock,
  input wire logic shift_data_pin,
  input wire logic reg_write_pulse,
  input wire logic serial_mode
);
  logic       sclk_q;
  logic [4:0] falls;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Falls counted here since a repetition cannot span sixteen edges
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclk_q <= 1'b0;
      falls  <= 5'h00;
    end
    else
    begin
      sclk_q <= shift_clock;
      if (port_select_n)
        falls <= 5'h00;
      else if (sclk_q && !shift_clock)
        falls <= falls + 5'h01;
    end
  end
  clk_in_frame_a: assert property (shift_clock |-> !port_select_n) else $error("clock outside frame");
  sel_setup_a: assert property ($fell(port_select_n) |-> !shift_clock [*3]) else $error("select setup");
  data_stable_a: assert property ($fell(shift_clock) && !port_select_n |-> $stable(shift_data_pin))
    else $error("data moved at fall");
  half_period_a: assert property ($rose(shift_clock) |-> shift_clock [*3]) else $error("clock too fast");
  word_commit_a: assert property ($fell(shift_clock) && !port_select_n && falls == 5'h0f
    |-> ##[3:5] reg_write_pulse) else $error("no commit after 16 falls");
  pulse_single_a: assert property (reg_write_pulse |=> !reg_write_pulse) else $error("pulse too long");
  reset_width_a: assert property ($rose(reset_pin) |=> reset_pin) else $error("reset pulse short");
  write_delay_a: assert property ($fell(reset_pin) |-> port_select_n [*3]) else $error("select too early");
  power_wait_a: assert property ($fell(rst) |=> !reset_pin [*8]) else $error("reset pulse too early");
  serial_on_a: assert property (!reset_pin [*5] |-> serial_mode) else $error("serial mode off");
  pin_mode_a: assert property (reset_pin [*5] |-> !serial_mode) else $error("serial mode on");
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_top;
  logic        clock, rst, write, read, reg_write_pulse;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic        serial_mode, ref_external, coarse_gain_on, cmos_interface, straight_binary;
  logic        adc_standby, output_buffers_off, clkout_buffer_off, global_power_down;
  logic [4:0]  reg_write_addr;
  logic [10:0] reg_write_data;
  logic [8:0]  cfg;
  int          n_fail, num_checks, cycles;
  assign cfg = {ref_external, coarse_gain_on, cmos_interface, straight_binary, adc_standby,
                output_buffers_off, clkout_buffer_off, global_power_down, serial_mode};
  acsp_link_if link ();
  acsp_host #(.POWER_ON_CYCLES(20)) u_acsp_host (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .write(write), .read(read), .rdata(rdata), .link(link));
  acsp_device u_acsp_device (.link(link), .clock(clock), .rst(rst), .serial_mode(serial_mode),
    .ref_external(ref_external), .coarse_gain_on(coarse_gain_on), .cmos_interface(cmos_interface),
    .straight_binary(straight_binary), .adc_standby(adc_standby), .output_buffers_off(output_buffers_off),
    .clkout_buffer_off(clkout_buffer_off), .global_power_down(global_power_down),
    .reg_write_pulse(reg_write_pulse), .reg_write_addr(reg_write_addr), .reg_write_data(reg_write_data));
  acsp_link_assertions u_acsp_link_assertions (.clock(clock), .rst(rst), .reset_pin(link.reset_pin),
    .port_select_n(link.port_select_n), .shift_clock(link.shift_clock), .shift_data_pin(link.shift_data_pin),
    .reg_write_pulse(reg_write_pulse), .serial_mode(serial_mode));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
    #1 d = rdata;
  endtask
  // Polls ready first: a command sent while busy would be dropped
  task automatic send(input logic [4:0] a, input logic [10:0] d);
    logic [31:0] s;
    int i;
    i = 0;
    do
    begin
      rd(acsp_pkg::HOST_REG_STATUS, s);
      i++;
    end
    while (s[1:0] !== 2'h2 && i < 300);
    wr(acsp_pkg::HOST_REG_COMMAND, {16'h0000, a, d});
    i = 0;
    do
    begin
      @(posedge clock);
      #1;
      i++;
    end
    while (reg_write_pulse !== 1'b1 && i < 300);
    check("word", {16'h0001, a, d}, {15'h0000, reg_write_pulse, reg_write_addr, reg_write_data});
    repeat (3) @(posedge clock);
  endtask
  task automatic t_serial();
    send(5'h00, 11'h721);
    check("cfg", 9'h1d9, cfg);
    send(5'h0a, 11'h400);
    check("cfg", 9'h1f9, cfg);
    send(5'h1f, 11'h555);
    check("cfg", 9'h1f9, cfg);
    send(5'h00, 11'h004);
    check("cfg", 9'h025, cfg);
    $display("test serial done");
  endtask
  task automatic t_resets();
    logic [31:0] s;
    send(5'h00, 11'h010);
    check("cfg", 9'h001, cfg);
    send(5'h00, 11'h401);
    wr(acsp_pkg::HOST_REG_CONTROL, 32'h00000080);
    // Command lands while the reset pulse runs, so it must be refused
    wr(acsp_pkg::HOST_REG_COMMAND, 32'h00000000);
    repeat (20) @(posedge clock);
    check("cfg", 9'h001, cfg);
    rd(acsp_pkg::HOST_REG_STATUS, s);
    check("status", 32'h0000000a, s);
    rd(acsp_pkg::HOST_REG_STATUS, s);
    check("status", 32'h00000002, s);
    $display("test resets done");
  endtask
  task automatic t_pins();
    logic [1:0] lv;
    for (int k = 0; k < 4; k++)
    begin
      lv = 2'(k);
      wr(acsp_pkg::HOST_REG_CONTROL, {25'h0000000, lv[0], lv[1], lv, lv, 1'b1});
      repeat (10) @(posedge clock);
      check("pin", {lv[0] ^ lv[1], lv[1], lv[1], lv[0] ^ lv[1], lv == 2'h3, 1'b0},
            {ref_external, coarse_gain_on, cmos_interface, straight_binary, global_power_down, serial_mode});
      if (lv != 2'h3)
        check("pwr", {lv == 2'h1, lv == 2'h2}, {adc_standby, output_buffers_off});
    end
    wr(acsp_pkg::HOST_REG_CONTROL, 32'h00000000);
    send(5'h0a, 11'h400);
    check("cfg", 9'h021, cfg);
    $display("test pins done");
  endtask
  // Ceiling covers all frames with generous polling slack
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    rst   = 1'b1;
    addr  = 4'h0;
    wdata = 32'h00000000;
    write = 1'b0;
    read  = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_serial();
    t_resets();
    t_pins();
    final_report();
  end
endmodule
`default_nettype wire
